// File: core/epvu_params.svh
// Constants for the exception priority and vector unit
// Functional notes
// - Table word zero holds initial stack pointer; exception n handler sits at 4*n.
// - Interrupt line n is exception n+16; lines 9-13, 38-42 reserved; 43 highest.
// - System reset puts the table base back at address zero.
// - Privileged relocation write moves the base; later fetches use it.
// - A smaller priority value is more urgent for selection and preemption.
// - Reset, hard fault and NMI have fixed negative priorities above all others.
// - Every configurable priority resets to zero.
// - Configurable priority fields hold values 0 to 7, three bits.
// - Equal most-urgent priorities resolve to the lowest exception number.
// - A strictly more urgent pending exception preempts the running handler.
// - Equal priority never preempts, but the newcomer still becomes pending.
// - Reset ranks highest, NMI is -2, hard fault is -1.
`ifndef EPVU_PARAMS_SVH
`define EPVU_PARAMS_SVH
`define EPVU_NIRQ 44
`define EPVU_IRQ_BASE 16
`define EPVU_IMPL_MASK 64'h083F_FFFF_C1FF_D87E
`define EPVU_PEND_RESET 64'h0000_0000_0000_0002
`define EPVU_EXC_RESET 6'h01
`define EPVU_EXC_NMI 6'h02
`define EPVU_EXC_HARD 6'h03
`define EPVU_PRIO_FIX_RESET 5'h1D
`define EPVU_PRIO_FIX_NMI 5'h1E
`define EPVU_PRIO_FIX_HARD 5'h1F
`define EPVU_PRIO_THREAD 5'h08
`define EPVU_PRIO_RESET_VAL 3'h0
`define EPVU_VTOR_RESET 22'h00_0000
`define EPVU_VTOR_LSB 8
`define EPVU_VTOR_MSB 29
`endif

// File: core/epvu_pkg.sv
// Types shared by the exception priority and vector unit
package epvu_pkg;
	typedef logic signed [4:0] epvu_prio_t;
	typedef logic [5:0] epvu_excnum_t;
endpackage : epvu_pkg

// File: core/epvu_arbiter.sv
// Combinational pick of the most urgent pending exception
`timescale 1ns/100ps
`default_nettype none
module epvu_arbiter #(
	parameter int N = 60
) (
	input wire logic [N-1:0] req,
	input var epvu_pkg::epvu_prio_t prio [N],
	output logic win_valid,
	output epvu_pkg::epvu_excnum_t win_num,
	output epvu_pkg::epvu_prio_t win_prio
);
	// The six-bit winner number cannot name more than 64 slots
	if (N < 2 || N > 64)
	begin : g_bad_n
		$error("epvu_arbiter: N out of range");
	end

	// Ascending scan with strict less-than keeps the lowest number on a tie
	always_comb
	begin
		win_valid = 1'b0;
		win_num = '0;
		win_prio = '0;
		for (int i = 0; i < N; i++)
		begin
			if (req[i] && (!win_valid || prio[i] < win_prio))
			begin
				win_valid = 1'b1;
				win_num = 6'(i);
				win_prio = prio[i];
			end
		end
	end
endmodule : epvu_arbiter
`default_nettype wire

// File: core/epvu_top.sv
// Exception priority ranking, preemption decision and vector address lookup
`timescale 1ns/100ps
`default_nettype none
`include "epvu_params.svh"
module epvu_top #(
	parameter int NIRQ = `EPVU_NIRQ
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [NIRQ-1:0] irq_in,
	input wire logic [15:0] sys_exc_set,
	input wire logic prio_wr,
	input wire logic [5:0] prio_num,
	input wire logic [2:0] prio_val,
	input wire logic vtor_wr,
	input wire logic vtor_priv,
	input wire logic [31:0] vtor_wdata,
	input wire logic entry_ack,
	input wire logic exc_return,
	input wire logic [5:0] ret_num,
	output logic exc_req,
	output logic [5:0] exc_num,
	output logic [4:0] exc_prio,
	output logic [31:0] exc_vector,
	output logic [31:0] vector_table_offset_reg,
	output logic [4:0] run_prio
);
	localparam int N = NIRQ + `EPVU_IRQ_BASE;
	localparam logic [N-1:0] IMPL = N'(`EPVU_IMPL_MASK);

	if (NIRQ < 1 || NIRQ > 48)
	begin : g_bad_nirq
		$error("epvu_top: NIRQ out of range");
	end

	function automatic logic [N-1:0] onehot(input logic [5:0] n);
		onehot = {{(N-1){1'b0}}, 1'b1} << n;
	endfunction : onehot

	logic [NIRQ-1:0] irq_s1_q;
	logic [NIRQ-1:0] irq_s2_q;
	logic [N-1:0] pending_q;
	logic [N-1:0] active_q;
	logic [2:0] prio_q [N];
	logic [`EPVU_VTOR_MSB:`EPVU_VTOR_LSB] vtor_q;
	epvu_pkg::epvu_prio_t prio_eff [N];
	epvu_pkg::epvu_prio_t run_d;
	epvu_pkg::epvu_prio_t win_prio;
	epvu_pkg::epvu_prio_t exc_prio_q;
	epvu_pkg::epvu_excnum_t win_num;
	logic win_valid;
	logic exc_req_q;
	logic [5:0] exc_num_q;
	logic [31:0] exc_vector_q;
	logic taking;
	logic [N-1:0] set_v;
	logic [N-1:0] clr_v;

	// Interrupt lines are asynchronous to mclk
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			irq_s1_q <= '0;
			irq_s2_q <= '0;
		end
		else
		begin
			irq_s1_q <= irq_in;
			irq_s2_q <= irq_s1_q;
		end
	end

	assign taking = entry_ack && exc_req_q;
	// Reserved slots are masked here so they can never win the arbiter
	assign set_v = {irq_s2_q, sys_exc_set} & IMPL;
	assign clr_v = taking ? onehot(exc_num_q) : '0;

	// Reset exception is pending out of reset so the first entry fetches slot one
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			pending_q <= N'(`EPVU_PEND_RESET);
		else
			pending_q <= (pending_q & ~clr_v) | set_v;
	end

	// Reset runs in thread mode, so it never raises the running priority
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			active_q <= '0;
		else
			active_q <= (active_q & ~(exc_return ? onehot(ret_num) : '0))
				| ((taking && exc_num_q != `EPVU_EXC_RESET) ? onehot(exc_num_q) : '0);
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < N; i++)
				prio_q[i] <= `EPVU_PRIO_RESET_VAL;
		end
		else if (prio_wr && int'(prio_num) < N && prio_num > `EPVU_EXC_HARD
			&& IMPL[prio_num])
			prio_q[prio_num] <= prio_val;
	end

	// Only the aligned upper bits are stored; low byte reads back as zero
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			vtor_q <= `EPVU_VTOR_RESET;
		else if (vtor_wr && vtor_priv)
			vtor_q <= vtor_wdata[`EPVU_VTOR_MSB:`EPVU_VTOR_LSB];
	end

	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			if (i == int'(`EPVU_EXC_RESET))
				prio_eff[i] = `EPVU_PRIO_FIX_RESET;
			else if (i == int'(`EPVU_EXC_NMI))
				prio_eff[i] = `EPVU_PRIO_FIX_NMI;
			else if (i == int'(`EPVU_EXC_HARD))
				prio_eff[i] = `EPVU_PRIO_FIX_HARD;
			else
				prio_eff[i] = {2'b00, prio_q[i]};
		end
	end

	always_comb
	begin
		run_d = `EPVU_PRIO_THREAD;
		for (int i = 0; i < N; i++)
		begin
			if (active_q[i] && prio_eff[i] < run_d)
				run_d = prio_eff[i];
		end
	end

	epvu_arbiter #(.N(N)) u_arb (
		.req(pending_q),
		.prio(prio_eff),
		.win_valid(win_valid),
		.win_num(win_num),
		.win_prio(win_prio)
	);

	// Request withheld in the ack cycle so a stale winner is not offered twice
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			exc_req_q <= 1'b0;
		else
			exc_req_q <= win_valid && (win_prio < run_d) && !taking;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			exc_num_q <= '0;
			exc_prio_q <= '0;
			exc_vector_q <= '0;
		end
		else
		begin
			exc_num_q <= win_num;
			exc_prio_q <= win_prio;
			exc_vector_q <= {2'b00, vtor_q, 8'h00} + ({26'h000_0000, win_num} << 2);
		end
	end

	assign exc_req = exc_req_q;
	assign exc_num = exc_num_q;
	assign exc_prio = exc_prio_q;
	assign exc_vector = exc_vector_q;
	assign vector_table_offset_reg = {2'b00, vtor_q, 8'h00};
	assign run_prio = run_d;

	logic tie_lower;
	always_comb
	begin
		tie_lower = 1'b0;
		for (int i = 0; i < N; i++)
		begin
			if (i < int'(win_num) && pending_q[i] && prio_eff[i] == win_prio)
				tie_lower = 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_reset_seen;
		$past(!resetn);
	endsequence

	property p_vec_addr;
		exc_req_q |-> exc_vector_q == {2'b00, $past(vtor_q), 8'h00} + ({26'h000_0000, exc_num_q} << 2);
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

	property p_irq_map;
		irq_s2_q[0] |=> pending_q[`EPVU_IRQ_BASE];
	endproperty
	a_irq_map: assert property (p_irq_map) else $error("line 0 not pending at 16");

	property p_base_reset;
		s_reset_seen |-> vtor_q == '0 && pending_q[1];
	endproperty
	a_base_reset: assert property (p_base_reset) else $error("base not zero after reset");

	property p_vtor_wr;
		vtor_wr && vtor_priv |=> vector_table_offset_reg == {2'b00, $past(vtor_wdata[29:8]), 8'h00};
	endproperty
	a_vtor_wr: assert property (p_vtor_wr) else $error("relocation write lost");

	property p_prio_reset;
		s_reset_seen |-> prio_q[`EPVU_IRQ_BASE] == 3'h0 && prio_q[4] == 3'h0;
	endproperty
	a_prio_reset: assert property (p_prio_reset) else $error("priority not reset");

	property p_prio_wr;
		prio_wr && prio_num == 6'h10 ##1 !prio_wr [*2] |-> prio_q[`EPVU_IRQ_BASE] == $past(prio_val, 2);
	endproperty
	a_prio_wr: assert property (p_prio_wr) else $error("priority field not stored");

	property p_nmi_wins;
		pending_q[2] && !pending_q[1] && !taking && active_q[3:1] == 3'b000
			|=> exc_req_q && exc_num_q == 6'h02;
	endproperty
	a_nmi_wins: assert property (p_nmi_wins) else $error("NMI did not win");

	property p_tie;
		win_valid |-> !tie_lower;
	endproperty
	a_tie: assert property (p_tie) else $error("tie not broken by lowest number");

	property p_strict;
		exc_req_q |-> exc_prio_q < $past(run_d);
	endproperty
	a_strict: assert property (p_strict) else $error("request too weak");

	property p_reserved;
		(pending_q & ~IMPL) == '0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved slot pending");
endmodule : epvu_top
`default_nettype wire

// File: dv/epvu_core_model.sv
// Partner model of the core's exception entry side
`timescale 1ns/100ps
`default_nettype none
module epvu_core_model (
	input wire logic mclk,
	input wire logic ack_req,
	input wire logic exc_req,
	output logic entry_ack
);
	logic done;
	logic go;
	initial entry_ack = 1'b0;
	initial done = 1'b0;
	// One take per request, and only while the unit asks
	always @(posedge mclk)
	begin
		go = ack_req && exc_req && !entry_ack && !done;
		#1;
		entry_ack = go;
		done = ack_req && (done || go);
	end
endmodule : epvu_core_model
`default_nettype wire

// File: dv/epvu_top_tb_top.sv
// Self-checking bench for the exception priority and vector unit
`timescale 1ns/100ps
`default_nettype none
module epvu_top_tb_top;
	logic mclk, resetn, prio_wr, vtor_wr, vtor_priv, entry_ack, exc_return, exc_req, ack_req;
	logic [43:0] irq_in;
	logic [15:0] sys_exc_set;
	logic [5:0] prio_num, ret_num, exc_num;
	logic [2:0] prio_val;
	logic [31:0] vtor_wdata, exc_vector, vto;
	logic [4:0] exc_prio, run_prio;
	int error_cnt = 0;
	int n_tests = 0;
	epvu_top u_epvu_top (.mclk(mclk), .resetn(resetn), .irq_in(irq_in),
		.sys_exc_set(sys_exc_set), .prio_wr(prio_wr), .prio_num(prio_num),
		.prio_val(prio_val), .vtor_wr(vtor_wr), .vtor_priv(vtor_priv),
		.vtor_wdata(vtor_wdata), .entry_ack(entry_ack), .exc_return(exc_return),
		.ret_num(ret_num), .exc_req(exc_req), .exc_num(exc_num), .exc_prio(exc_prio),
		.exc_vector(exc_vector), .vector_table_offset_reg(vto), .run_prio(run_prio));
	epvu_core_model u_epvu_core_model (.mclk(mclk), .ack_req(ack_req),
		.exc_req(exc_req), .entry_ack(entry_ack));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		if (error_cnt == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic do_reset;
		resetn = 1'b0;
		step(10);
		resetn = 1'b1;
		step(1);
	endtask : do_reset
	task automatic take;
		ack_req = 1'b1;
		step(3);
		ack_req = 1'b0;
		step(2);
	endtask : take
	task automatic sys(input int k);
		sys_exc_set[k] = 1'b1;
		step(1);
		sys_exc_set = 16'h0000;
		step(3);
	endtask : sys
	task automatic wprio(input logic [5:0] n, input logic [2:0] v);
		prio_wr = 1'b1;
		prio_num = n;
		prio_val = v;
		step(1);
		prio_wr = 1'b0;
		step(3);
	endtask : wprio
	task automatic wvtor(input logic p, input logic [31:0] d);
		vtor_wr = 1'b1;
		vtor_priv = p;
		vtor_wdata = d;
		step(1);
		vtor_wr = 1'b0;
		step(2);
	endtask : wvtor
	task automatic t_reset;
		chk("req", exc_req, 32'h1);
		chk("num", exc_num, 32'h01);
		chk("prio", exc_prio, 32'h1D);
		chk("vec", exc_vector, 32'h4);
		// Fetch address stays word aligned; the handler's bit zero lives in the stored word
		chk("vec align", {30'h0000_0000, exc_vector[1:0]}, 32'h0);
		chk("base", vto, 32'h0);
		take();
		chk("req", exc_req, 32'h0);
		chk("run", run_prio, 32'h08);
	endtask : t_reset
	task automatic t_vtor;
		wvtor(1'b0, 32'h1000_0000);
		chk("base", vto, 32'h0);
		wvtor(1'b1, 32'h2000_0100);
		chk("base", vto, 32'h2000_0100);
	endtask : t_vtor
	task automatic t_irq;
		irq_in[9] = 1'b1;
		// Exception zero and the reserved system slots must not pend either
		sys_exc_set = 16'h2781;
		step(6);
		chk("req", exc_req, 32'h0);
		sys_exc_set = 16'h0000;
		irq_in[1:0] = 2'b11;
		step(6);
		chk("num", exc_num, 32'h10);
		chk("vec", exc_vector, 32'h2000_0140);
		chk("prio", exc_prio, 32'h00);
		wprio(6'h10, 3'h5);
		chk("num", exc_num, 32'h11);
		chk("vec", exc_vector, 32'h2000_0144);
	endtask : t_irq
	task automatic t_preempt;
		take();
		chk("req", exc_req, 32'h0);
		chk("run", run_prio, 32'h00);
		sys(2);
		chk("num", exc_num, 32'h02);
		chk("prio", exc_prio, 32'h1E);
		chk("vec", exc_vector, 32'h2000_0108);
		take();
		chk("run", run_prio, 32'h1E);
		sys(3);
		chk("req", exc_req, 32'h0);
		exc_return = 1'b1;
		ret_num = 6'h02;
		step(1);
		exc_return = 1'b0;
		step(3);
		chk("num", exc_num, 32'h03);
		chk("prio", exc_prio, 32'h1F);
		chk("vec", exc_vector, 32'h2000_010C);
	endtask : t_preempt
	task automatic t_rereset;
		do_reset();
		chk("base", vto, 32'h0);
		take();
		step(4);
		// Line 1 was more urgent before reset; a lost reset of line 0's priority shows here
		chk("num", exc_num, 32'h10);
		chk("vec", exc_vector, 32'h40);
	endtask : t_rereset
	initial
	begin
		{prio_wr, vtor_wr, vtor_priv, exc_return, ack_req} = 5'h00;
		irq_in = 44'h0;
		sys_exc_set = 16'h0000;
		{prio_num, ret_num, prio_val} = 15'h0000;
		vtor_wdata = 32'h0;
		do_reset();
		t_reset();
		t_vtor();
		t_irq();
		t_preempt();
		t_rereset();
		end_of_test();
	end
	initial
	begin
		repeat (2000) @(posedge mclk);
		error_cnt++;
		end_of_test();
	end
endmodule : epvu_top_tb_top
`default_nettype wire
